// file: verilog/oag_pkg.sv
/*
  Constants for the operand and branch address generator.
  Assumes a single 200 MHz core clock and an 8-bit core around it.
*/
`default_nettype none
package oag_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned CLKS_PER_MC     = 4;
  localparam int unsigned CLKS_PER_TICK   = 12;
  localparam int unsigned MAX_CYCLES      = 5;
  localparam logic [7:0]  DIRECT_TOP      = 8'h7F;
  localparam logic [7:0]  BIT_RAM_BASE    = 8'h20;
  localparam logic [7:0]  STATUS_WORD_ADDR = 8'hD0;
  localparam int unsigned BANK_LSB        = 3;
  localparam logic [15:0] ONCHIP_TOP_DEF  = 16'h1FFF;
  localparam logic [2:0]  STD_EXTRA_MULT  = 3'h4;
  localparam logic [2:0]  STD_EXTRA_TBL   = 3'h2;
  localparam logic [2:0]  STD_EXTRA_XDM   = 3'h1;
  localparam logic [2:0]  STD_EXTRA_BR    = 3'h1;
  localparam logic [2:0]  CYC_ONE         = 3'h1;
  localparam logic [2:0]  CYC_XWIDE       = 3'h2;
  localparam logic [2:0]  CYC_D2D         = 3'h3;

  typedef enum logic [3:0] {
    OAG_MODE_WREG   = 4'h0,
    OAG_MODE_DIRECT = 4'h1,
    OAG_MODE_BIT    = 4'h2,
    OAG_MODE_IND    = 4'h3,
    OAG_MODE_STACK  = 4'h4,
    OAG_MODE_XPAGE  = 4'h5,
    OAG_MODE_XWIDE  = 4'h6,
    OAG_MODE_IMM    = 4'h7,
    OAG_MODE_TABLE  = 4'h8,
    OAG_MODE_REL    = 4'h9,
    OAG_MODE_PAGE   = 4'hA,
    OAG_MODE_EXT    = 4'hB
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_SPACE_RAM   = 2'h0,
    OAG_SPACE_SPECIAL = 2'h1,
    OAG_SPACE_XDATA = 2'h2,
    OAG_SPACE_CODE  = 2'h3
  } oag_space_t;

  typedef enum logic [1:0] {
    OAG_ST_IDLE = 2'b00,
    OAG_ST_EXEC = 2'b01
  } oag_state_t;
endpackage
`default_nettype wire

// file: verilog/oag_core.sv
/*
  Operand and branch address generator with instruction cycle timing.
  Assumes the decoder ahead of it presents one decoded instruction per
  request, with opcode and operand bytes already fetched.
*/
// Notes on behaviour
// RULE1 - Operation and flag effects match the standard set; only timing differs.
// RULE2 - Machine cycle is four clocks with one address latch pulse each.
// RULE3 - Timer tick advances once every twelve input clocks by default.
// RULE4 - Duration is one cycle per byte, except multiply, divide, table, move, branch.
// RULE5 - Wide-pointer external move takes two cycles; direct-to-direct move three.
// RULE6 - Instructions take one to five machine cycles.
// RULE7 - Program, data and register spaces are separate address spaces.
// RULE8 - Program memory is fetch-only; fetch routed on-chip or off-chip by address.
// RULE9 - Working registers sit in lowest 32 RAM bytes, bank from status word bits.
// RULE10 - Working-register instructions complete in one machine cycle.
// RULE11 - Direct 00h-7Fh is RAM; above 7Fh is special-function space.
// RULE12 - Bit operands reach RAM 20h-2Fh and special registers ending 0 or 8.
// RULE13 - Bit 00h is RAM 20h bit 0; bit B7 is register B0h bit 7.
// RULE14 - Indirect access uses pointer zero or one, reaching upper RAM too.
// RULE15 - Push and pop address RAM through the stack pointer.
// RULE16 - Paged external move: pointer low byte, port two latch high byte.
// RULE17 - Wide external move uses the selected 16-bit data pointer.
// RULE18 - Immediate operands come from the instruction bytes.
// RULE19 - Table read address is accumulator plus PC or data pointer.
// RULE20 - Taken conditional branch adds signed offset to next address.
// RULE21 - Page branch keeps upper five bits of next address, adds 11-bit field.
// RULE22 - Extended branch loads the 16-bit absolute target.
// RULE23 - Each instruction starts with one opcode; decode says how many more bytes.
// RULE24 - Working register n of bank b sits at RAM address 8*b+n.
`timescale 1ns/100ps
`default_nettype none
module oag_core
  import oag_pkg::*;
#(
  parameter logic [15:0] ONCHIP_TOP = ONCHIP_TOP_DEF
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // Decoded instruction request
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire oag_mode_t   mode_in,
  input  wire logic [1:0]  inst_bytes_in,
  input  wire logic [2:0]  std_extra_in,
  input  wire logic        dir_to_dir_in,
  input  wire logic [2:0]  reg_sel_in,
  input  wire logic        ptr_sel_in,
  input  wire logic [7:0]  op1_in,
  input  wire logic [7:0]  op2_in,
  input  wire logic [2:0]  page_hi_in,
  input  wire logic        cond_true_in,
  input  wire logic        table_dptr_in,
  // Core state seen by the generator
  input  wire logic [7:0]  psw_in,
  input  wire logic [7:0]  ptr0_in,
  input  wire logic [7:0]  ptr1_in,
  input  wire logic [7:0]  sp_in,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  port_two_latch_in,
  input  wire logic [15:0] wide_ptr0_in,
  input  wire logic [15:0] wide_ptr1_in,
  input  wire logic        dptr_sel_in,
  input  wire logic [15:0] pc_next_in,
  // Operand address result
  output logic             addr_valid_out,
  output oag_space_t       space_out,
  output logic [15:0]      addr_out,
  output logic [2:0]       bit_pos_out,
  output logic             is_imm_out,
  output logic [7:0]       imm_out,
  output logic             fetch_onchip_out,
  output logic             code_write_out,
  // Branch result
  output logic             branch_out,
  output logic [15:0]      target_out,
  // Timing
  output logic [2:0]       cycles_out,
  output logic             done_out,
  output logic             ale_out,
  output logic             timer_tick_out
);

  // Refused at elaboration: an on-chip code window of address 0000h only
  if (ONCHIP_TOP == 16'h0000) begin
    $error("ONCHIP_TOP must be nonzero");
  end

  // Cycle count of one instruction
  function automatic logic [2:0] inst_cycles(input oag_mode_t m, input logic [1:0] nb,
                                             input logic [2:0] extra, input logic d2d);
    logic [2:0] c;
    c = {1'b0, nb}; // RULE4 RULE23
    if (m == OAG_MODE_WREG) begin
      c = CYC_ONE; // RULE10
    end else if (m == OAG_MODE_XWIDE) begin
      c = CYC_XWIDE; // RULE5
    end else if (d2d) begin
      c = CYC_D2D; // RULE5
    end else if (extra != 3'h0) begin
      c = extra; // RULE4
    end
    if (c == 3'h0) begin
      c = CYC_ONE;
    end else if (c > 3'(MAX_CYCLES)) begin
      c = 3'(MAX_CYCLES); // RULE6
    end
    return c;
  endfunction

  // Working register address in the active bank
  function automatic logic [7:0] wreg_addr(input logic [7:0] program_status_word, input logic [2:0] n);
    return {3'h0, program_status_word[BANK_LSB+1:BANK_LSB], n}; // RULE9 RULE24
  endfunction

  // Machine cycle phase and timer prescaler
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [3:0] tick_q;
  logic [3:0] tick_d;
  wire        mc_end   = (phase_q == 2'(CLKS_PER_MC - 1));
  wire        tick_end = (tick_q == 4'(CLKS_PER_TICK - 1));
  assign phase_d = mc_end ? 2'h0 : phase_q + 2'h1; // RULE2
  assign tick_d  = tick_end ? 4'h0 : tick_q + 4'h1; // RULE3

  // Instruction state
  oag_state_t st_q;
  oag_state_t st_d;
  logic [2:0] left_q;
  logic [2:0] left_d;

  wire accept   = (st_q == OAG_ST_IDLE) && req_valid_in && mc_end;
  wire last_mc  = (st_q == OAG_ST_EXEC) && mc_end && (left_q == 3'h1);
  wire [2:0] ncyc = inst_cycles(mode_in, inst_bytes_in, std_extra_in, dir_to_dir_in);

  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    unique case (st_q)
      OAG_ST_IDLE: begin
        if (accept) begin
          st_d   = OAG_ST_EXEC;
          left_d = ncyc;
        end
      end
      OAG_ST_EXEC: begin
        if (mc_end) begin
          left_d = left_q - 3'h1;
          if (left_q == 3'h1) begin
            st_d = OAG_ST_IDLE;
          end
        end
      end
    endcase
  end

  assign req_ready_out = (st_q == OAG_ST_IDLE) && mc_end;

  // Address decode
  wire [7:0]  ptr_val   = ptr_sel_in ? ptr1_in : ptr0_in; // RULE14
  wire [15:0] dptr_val  = dptr_sel_in ? wide_ptr1_in : wide_ptr0_in; // RULE17
  wire        bit_in_special = op1_in[7];
  wire [7:0]  bit_byte  = bit_in_special ? {op1_in[7:3], 3'h0}
                                     : BIT_RAM_BASE + {4'h0, op1_in[6:3]}; // RULE12 RULE13
  wire [15:0] tbl_base  = table_dptr_in ? dptr_val : pc_next_in;
  wire [15:0] tbl_addr  = tbl_base + {8'h00, acc_in}; // RULE19
  wire [15:0] rel_tgt   = pc_next_in + {{8{op1_in[7]}}, op1_in}; // RULE20
  wire [15:0] page_tgt  = {pc_next_in[15:11], page_hi_in, op1_in}; // RULE21
  wire [15:0] ext_tgt   = {op1_in, op2_in}; // RULE22
  wire        dir_special = (op1_in > DIRECT_TOP); // RULE11

  oag_space_t sp_d;
  logic [15:0] ad_d;
  logic [2:0]  bp_d;
  logic        br_d;
  logic [15:0] tg_d;

  always_comb begin
    sp_d = OAG_SPACE_RAM;
    ad_d = 16'h0000;
    bp_d = 3'h0;
    br_d = 1'b0;
    tg_d = pc_next_in;
    unique case (mode_in)
      OAG_MODE_WREG:   ad_d = {8'h00, wreg_addr(psw_in, reg_sel_in)};
      OAG_MODE_DIRECT: begin
        sp_d = dir_special ? OAG_SPACE_SPECIAL : OAG_SPACE_RAM; // RULE7 RULE11
        ad_d = {8'h00, op1_in};
      end
      OAG_MODE_BIT: begin
        sp_d = bit_in_special ? OAG_SPACE_SPECIAL : OAG_SPACE_RAM;
        ad_d = {8'h00, bit_byte};
        bp_d = op1_in[2:0]; // RULE13
      end
      OAG_MODE_IND:    ad_d = {8'h00, ptr_val}; // RULE14
      OAG_MODE_STACK:  ad_d = {8'h00, sp_in}; // RULE15
      OAG_MODE_XPAGE: begin
        sp_d = OAG_SPACE_XDATA;
        ad_d = {port_two_latch_in, ptr_val}; // RULE16
      end
      OAG_MODE_XWIDE: begin
        sp_d = OAG_SPACE_XDATA;
        ad_d = dptr_val; // RULE17
      end
      OAG_MODE_IMM:    ad_d = 16'h0000; // RULE18
      OAG_MODE_TABLE: begin
        sp_d = OAG_SPACE_CODE;
        ad_d = tbl_addr; // RULE19
      end
      OAG_MODE_REL: begin
        br_d = cond_true_in;
        tg_d = cond_true_in ? rel_tgt : pc_next_in; // RULE20
      end
      OAG_MODE_PAGE: begin
        br_d = 1'b1;
        tg_d = page_tgt;
      end
      OAG_MODE_EXT: begin
        br_d = 1'b1;
        tg_d = ext_tgt;
      end
      default: ad_d = 16'h0000;
    endcase
  end

  // Code space routing follows the fetch or table address
  wire [15:0] code_addr = (mode_in == OAG_MODE_TABLE) ? tbl_addr : pc_next_in;
  wire        onchip_d  = (code_addr <= ONCHIP_TOP); // RULE8

  // Registered outputs
  logic       av_q;
  oag_space_t sp_q;
  logic [15:0] ad_q;
  logic [2:0] bp_q;
  logic       im_q;
  logic [7:0] iv_q;
  logic       oc_q;
  logic       br_q;
  logic [15:0] tg_q;
  logic [2:0] cy_q;
  logic       dn_q;
  logic       ale_q;
  logic       tt_q;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q <= 2'h0;
      tick_q  <= 4'h0;
      st_q    <= OAG_ST_IDLE;
      left_q  <= 3'h0;
      ale_q   <= 1'b0;
      tt_q    <= 1'b0;
      dn_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tick_q  <= tick_d;
      st_q    <= st_d;
      left_q  <= left_d;
      ale_q   <= mc_end; // RULE2
      tt_q    <= tick_end; // RULE3
      dn_q    <= last_mc; // RULE6
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      av_q <= 1'b0;
      sp_q <= OAG_SPACE_RAM;
      ad_q <= 16'h0000;
      bp_q <= 3'h0;
      im_q <= 1'b0;
      iv_q <= 8'h00;
      oc_q <= 1'b0;
      br_q <= 1'b0;
      tg_q <= 16'h0000;
      cy_q <= 3'h0;
    end else begin
      av_q <= accept;
      if (accept) begin
        sp_q <= sp_d;
        ad_q <= ad_d;
        bp_q <= bp_d;
        im_q <= (mode_in == OAG_MODE_IMM);
        iv_q <= op1_in; // RULE18
        oc_q <= onchip_d;
        br_q <= br_d;
        tg_q <= tg_d;
        cy_q <= ncyc;
      end
    end
  end

  assign addr_valid_out   = av_q;
  assign space_out        = sp_q;
  assign addr_out         = ad_q;
  assign bit_pos_out      = bp_q;
  assign is_imm_out       = im_q;
  assign imm_out          = iv_q;
  assign fetch_onchip_out = oc_q;
  assign code_write_out   = 1'b0; // RULE8
  assign branch_out       = br_q;
  assign target_out       = tg_q;
  assign cycles_out       = cy_q; // RULE1
  assign done_out         = dn_q;
  assign ale_out          = ale_q;
  assign timer_tick_out   = tt_q;

endmodule
`default_nettype wire

// file: bench/oag_props.sv
/* Port checker for the operand and branch address generator.
   Assumes one core clock domain and is bound to every oag_core. */
`timescale 1ns/100ps
`default_nettype none
module oag_props
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  // Request side
  input wire logic        req_valid_in,
  input wire logic        req_ready_out,
  input wire oag_mode_t   mode_in,
  input wire logic [2:0]  reg_sel_in,
  input wire logic [7:0]  op1_in,
  input wire logic [7:0]  op2_in,
  input wire logic [7:0]  psw_in,
  // Results
  input wire logic        addr_valid_out,
  input wire oag_space_t  space_out,
  input wire logic [15:0] addr_out,
  input wire logic        code_write_out,
  input wire logic        branch_out,
  input wire logic [15:0] target_out,
  input wire logic [2:0]  cycles_out,
  input wire logic        done_out,
  input wire logic        ale_out,
  input wire logic        timer_tick_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic take = req_valid_in && req_ready_out;

  property p_ale;
    ale_out |=> !ale_out [*3] ##1 ale_out;
  endproperty
  a_ale: assert property (p_ale) else $error("ale spacing wrong");
  property p_tick;
    timer_tick_out |=> !timer_tick_out [*8] ##1 !timer_tick_out [*3] ##1 timer_tick_out;
  endproperty
  a_tick: assert property (p_tick) else $error("timer tick spacing wrong");
  property p_ans;
    take |=> addr_valid_out;
  endproperty
  a_ans: assert property (p_ans) else $error("no result after accept");
  property p_wreg;
    take && mode_in == OAG_MODE_WREG |=> cycles_out == 3'h1
      && addr_out == {11'h000, $past(psw_in[4:3]), $past(reg_sel_in)};
  endproperty
  a_wreg: assert property (p_wreg) else $error("working register wrong");
  property p_dir;
    take && mode_in == OAG_MODE_DIRECT |=> space_out ==
      ($past(op1_in) > DIRECT_TOP ? OAG_SPACE_SPECIAL : OAG_SPACE_RAM);
  endproperty
  a_dir: assert property (p_dir) else $error("direct space wrong");
  property p_ext;
    take && mode_in == OAG_MODE_EXT |=> branch_out && target_out == {$past(op1_in), $past(op2_in)};
  endproperty
  a_ext: assert property (p_ext) else $error("extended target wrong");
  property p_cyc;
    addr_valid_out |-> cycles_out inside {[3'h1:3'h5]};
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle count out of range");
  property p_one;
    addr_valid_out && cycles_out == 3'h1 |-> ##4 done_out;
  endproperty
  a_one: assert property (p_one) else $error("single cycle done late");
  property p_cw;
    !code_write_out;
  endproperty
  a_cw: assert property (p_cw) else $error("code space written");
  c_ext: cover property (take && mode_in == OAG_MODE_EXT);
  c_five: cover property (done_out && cycles_out == 3'h5);
  c_xd: cover property (addr_valid_out && space_out == OAG_SPACE_XDATA);
endmodule
bind oag_core oag_props i_oag_props (.*);
`default_nettype wire

// file: bench/oag_mem.sv
/* Behavioural program and data memory beyond the external bus.
   Assumes the generator's space and address select each access. */
`timescale 1ns/100ps
`default_nettype none
module oag_mem
  import oag_pkg::*;
(
  // Access
  input  wire logic        core_clk_in,
  input  wire oag_space_t  space_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  wdata_in,
  // Read data
  output logic [7:0]       rdata_out
);
  logic [7:0] xdata_q [0:65535];
  // Code space has no write path at all
  wire logic [7:0] code_rd = addr_in[15:8] ^ addr_in[7:0];
  always_ff @(posedge core_clk_in) begin
    if (wr_in && space_in == OAG_SPACE_XDATA) begin
      xdata_q[addr_in] <= wdata_in;
    end
  end
  assign rdata_out = (space_in == OAG_SPACE_CODE) ? code_rd : xdata_q[addr_in];
endmodule
`default_nettype wire

// file: bench/oag_core_tb.sv
/* Self-checking bench for the address generator, one task per scenario.
   Assumes the package constants and a 200 MHz core clock. */
`timescale 1ns/100ps
`default_nettype none
module oag_core_tb;
  import oag_pkg::*;
  logic core_clk_in, nrst_in, req_valid_in, req_ready_out, dir_to_dir_in, ptr_sel_in;
  logic cond_true_in, table_dptr_in, dptr_sel_in, addr_valid_out, is_imm_out, mem_wr;
  logic fetch_onchip_out, code_write_out, branch_out, done_out, ale_out, timer_tick_out;
  logic [1:0] inst_bytes_in;
  logic [2:0] std_extra_in, reg_sel_in, page_hi_in, bit_pos_out, cycles_out;
  logic [7:0] op1_in, op2_in, psw_in, ptr0_in, ptr1_in, sp_in, acc_in, port_two_latch_in;
  logic [7:0] rdata, imm_out;
  logic [15:0] wide_ptr0_in, wide_ptr1_in, pc_next_in, addr_out, target_out;
  oag_mode_t mode_in;
  oag_space_t space_out;
  int mismatches, n_tests;
  oag_core i_oag_core (.*);
  oag_mem i_oag_mem (.core_clk_in(core_clk_in), .space_in(space_out), .addr_in(addr_out),
    .wr_in(mem_wr), .wdata_in(acc_in), .rdata_out(rdata));
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic set(input oag_mode_t m, input logic [1:0] b, input logic [2:0] x,
                     input logic [7:0] a, input logic [7:0] c);
    mode_in = m;
    inst_bytes_in = b;
    std_extra_in = x;
    op1_in = a;
    op2_in = c;
    dir_to_dir_in = 1'b0;
  endtask
  // Offer, wait for accept, then time the done pulse
  task automatic issue(input logic [2:0] n);
    int k;
    k = 0;
    req_valid_in = 1'b1;
    while (req_ready_out !== 1'b1) begin
      @(negedge core_clk_in);
      k++;
      if (k > 20) begin
        mismatches++;
        stop_test();
      end
    end
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    chk("valid", addr_valid_out, 16'h1);
    chk("cycles", cycles_out, n);
    k = 0;
    while (done_out !== 1'b1) begin
      @(negedge core_clk_in);
      k++;
      if (k > 30) begin
        mismatches++;
        stop_test();
      end
    end
    chk("done", k, 4 * n);
  endtask
  // Pulse rates over a window of two timer periods
  task automatic t_timing();
    int na, nt;
    na = 0;
    nt = 0;
    repeat (24) begin
      @(negedge core_clk_in);
      if (ale_out === 1'b1) na++;
      if (timer_tick_out === 1'b1) nt++;
    end
    chk("ale", na, 32'h6);
    chk("tick", nt, 32'h2);
    chk("code_wr", code_write_out, 32'h0);
  endtask
  task automatic t_wreg();
    psw_in = 8'h10;
    reg_sel_in = 3'h5;
    set(OAG_MODE_WREG, 2'h1, 3'h0, 8'h00, 8'h00);
    issue(3'h1);
    chk("wreg", addr_out, 16'h0015);
  endtask
  task automatic t_direct();
    set(OAG_MODE_DIRECT, 2'h2, 3'h0, 8'h7F, 8'h00);
    issue(3'h2);
    chk("ram", space_out, OAG_SPACE_RAM);
    set(OAG_MODE_DIRECT, 2'h2, 3'h0, 8'h80, 8'h00);
    issue(3'h2);
    chk("special", space_out, OAG_SPACE_SPECIAL);
  endtask
  task automatic t_bit();
    set(OAG_MODE_BIT, 2'h2, 3'h0, 8'h00, 8'h00);
    issue(3'h2);
    chk("bit0", {space_out, addr_out[7:0], bit_pos_out}, {2'h0, 8'h20, 3'h0});
    set(OAG_MODE_BIT, 2'h2, 3'h0, 8'hB7, 8'h00);
    issue(3'h2);
    chk("bitB7", {space_out, addr_out[7:0], bit_pos_out}, {2'h1, 8'hB0, 3'h7});
  endtask
  task automatic t_ind();
    ptr1_in = 8'h9A;
    ptr_sel_in = 1'b1;
    set(OAG_MODE_IND, 2'h1, 3'h0, 8'h00, 8'h00);
    issue(3'h1);
    chk("ind", {space_out, addr_out}, {2'h0, 16'h009A});
    sp_in = 8'h47;
    set(OAG_MODE_STACK, 2'h2, 3'h0, 8'h00, 8'h00);
    issue(3'h2);
    chk("stack", addr_out, 16'h0047);
  endtask
  task automatic t_xmove();
    port_two_latch_in = 8'h3C;
    ptr0_in = 8'h5D;
    ptr_sel_in = 1'b0;
    set(OAG_MODE_XPAGE, 2'h1, 3'h2, 8'h00, 8'h00);
    issue(3'h2);
    chk("xpage", {space_out, addr_out}, {2'h2, 16'h3C5D});
    wide_ptr1_in = 16'hBEEF;
    dptr_sel_in = 1'b1;
    set(OAG_MODE_XWIDE, 2'h1, 3'h0, 8'h00, 8'h00);
    issue(3'h2);
    chk("xwide", {space_out, addr_out}, {2'h2, 16'hBEEF});
    acc_in = 8'h5A;
    mem_wr = 1'b1;
    @(negedge core_clk_in);
    mem_wr = 1'b0;
    chk("xdata", rdata, 32'h5A);
  endtask
  task automatic t_imm();
    set(OAG_MODE_IMM, 2'h2, 3'h0, 8'h40, 8'h00);
    issue(3'h2);
    chk("imm", {is_imm_out, imm_out}, 16'h0140);
  endtask
  task automatic t_table();
    acc_in = 8'h10;
    wide_ptr0_in = 16'h1FF8;
    dptr_sel_in = 1'b0;
    table_dptr_in = 1'b1;
    set(OAG_MODE_TABLE, 2'h1, 3'h2, 8'h00, 8'h00);
    issue(3'h2);
    chk("tbl_dp", {space_out, fetch_onchip_out, addr_out}, {2'h3, 1'b0, 16'h2008});
    chk("tbl_dp_rd", rdata, 32'h28);
    table_dptr_in = 1'b0;
    pc_next_in = 16'h0100;
    issue(3'h2);
    chk("tbl_pc", {space_out, fetch_onchip_out, addr_out}, {2'h3, 1'b1, 16'h0110});
    chk("tbl_pc_rd", rdata, 32'h11);
  endtask
  task automatic t_branch();
    pc_next_in = 16'h0102;
    cond_true_in = 1'b1;
    set(OAG_MODE_REL, 2'h2, 3'h2, 8'hEC, 8'h00);
    issue(3'h2);
    chk("rel", {branch_out, target_out}, {1'b1, 16'h00EE});
    cond_true_in = 1'b0;
    issue(3'h2);
    chk("rel_nt", {branch_out, target_out}, {1'b0, 16'h0102});
    pc_next_in = 16'h0872;
    page_hi_in = 3'h1;
    set(OAG_MODE_PAGE, 2'h2, 3'h2, 8'h00, 8'h00);
    issue(3'h2);
    chk("page", target_out, 16'h0900);
    set(OAG_MODE_EXT, 2'h3, 3'h2, 8'hF7, 8'h32);
    issue(3'h2);
    chk("ext", {branch_out, target_out}, {1'b1, 16'hF732});
  endtask
  task automatic t_counts();
    set(OAG_MODE_DIRECT, 2'h3, 3'h0, 8'h72, 8'h74);
    dir_to_dir_in = 1'b1;
    issue(3'h3);
    set(OAG_MODE_DIRECT, 2'h1, 3'h4, 8'h10, 8'h00);
    issue(3'h4);
    set(OAG_MODE_DIRECT, 2'h1, 3'h5, 8'h10, 8'h00);
    issue(3'h5);
  endtask
  initial begin
    {nrst_in, req_valid_in, dir_to_dir_in, ptr_sel_in, cond_true_in, mem_wr} = '0;
    {table_dptr_in, dptr_sel_in, inst_bytes_in, std_extra_in, reg_sel_in, page_hi_in} = '0;
    {op1_in, op2_in, psw_in, ptr0_in, ptr1_in, sp_in, acc_in, port_two_latch_in} = '0;
    {wide_ptr0_in, wide_ptr1_in, pc_next_in} = '0;
    mode_in = OAG_MODE_WREG;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(negedge core_clk_in);
    nrst_in = 1'b1;
    t_timing();
    t_wreg();
    t_direct();
    t_bit();
    t_ind();
    t_xmove();
    t_imm();
    t_table();
    t_branch();
    t_counts();
    stop_test();
  end
endmodule
`default_nettype wire
